// [core/dph_port_ctrl.sv]
/*
  One-port controller for an asynchronous dual-port static RAM with
  contention flag, mailbox flags and token latches. Turns single requests
  into pin sequences and answers with captured data.
  Assumes: one device port on the pins, 10 MHz MCLK, device pins settle
  well inside one clock period; contention and mailbox inputs asynchronous.
*/
`default_nettype none
`include "dph_port_regs.svh"

module dph_port_ctrl (
  input  wire logic                   MCLK,
  input  wire logic                   RESET_N,
  input  wire dph_pkg::dph_req_s      REQ,
  input  wire logic                   REQ_VALID,
  output logic                        REQ_READY,
  output var  dph_pkg::dph_rsp_s      RSP,
  output logic                        RSP_VALID,
  output var  dph_pkg::dph_pins_s     PINS,
  input  wire logic [`DPH_DATA_W-1:0] DQ_IN,
  input  wire logic                   CONTENTION_N_IN,
  input  wire logic                   MAILBOX_N_IN,
  output logic                        MAILBOX_PENDING
);
  import dph_pkg::*;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + `DPH_MCLK_NS - 1) / `DPH_MCLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic is_write(input dph_kind_e k);
    return k != DPH_MEM_RD;
  endfunction

  function automatic logic is_token(input dph_kind_e k);
    return (k == DPH_TOK_WR) || (k == DPH_TOK_ACQ);
  endfunction

  localparam int WR_PULSE_CYC = cyc_up(max2(`DPH_WRITE_PULSE_MIN_NS,
                                            `DPH_WRITE_TURNOFF_NS + `DPH_DATA_SETUP_NS));
  localparam int MEM_RD_CYC   = cyc_up(max2(`DPH_SELECT_ACCESS_NS, `DPH_CROSS_PORT_DELAY_NS));
  localparam int TOK_RD_CYC   = cyc_up(`DPH_TOKEN_WRITE_TO_READ_NS + `DPH_OE_ACCESS_NS);
  localparam int WR_HOLD_CYC  = cyc_up(`DPH_RELEASE_STROBE_HOLD_NS);
  localparam int RD_HOLD_CYC  = cyc_up(`DPH_RELEASE_DATA_DELAY_NS);
  localparam int GAP_CYC      = cyc_up(`DPH_TOKEN_UPDATE_PULSE_NS);

  localparam logic [`DPH_CNT_W-1:0] LD_WR  = `DPH_CNT_W'(WR_PULSE_CYC + `DPH_SYNC_LAT - 1);
  localparam logic [`DPH_CNT_W-1:0] LD_MRD = `DPH_CNT_W'(MEM_RD_CYC + `DPH_SYNC_LAT - 1);
  localparam logic [`DPH_CNT_W-1:0] LD_TRD = `DPH_CNT_W'(TOK_RD_CYC + `DPH_SYNC_LAT - 1);
  localparam logic [`DPH_CNT_W-1:0] LD_WRH = `DPH_CNT_W'(WR_HOLD_CYC - 1);
  localparam logic [`DPH_CNT_W-1:0] LD_RDH = `DPH_CNT_W'(RD_HOLD_CYC + `DPH_SYNC_LAT - 1);
  localparam logic [`DPH_CNT_W-1:0] LD_GAP = `DPH_CNT_W'(GAP_CYC - 1);
  localparam logic [`DPH_CNT_W-1:0] CNT_ZERO = `DPH_CNT_W'(0);
  localparam logic [`DPH_CNT_W-1:0] CNT_ONE  = `DPH_CNT_W'(1);

  logic                   rst_meta;
  logic                   rst_n;
  logic [`DPH_SYNC_W-1:0] sync1;
  logic [`DPH_SYNC_W-1:0] sync2;
  logic [`DPH_SYNC_W-1:0] sync3;
  logic [`DPH_SYNC_W-1:0] agreed;
  logic [`DPH_SYNC_W-1:0] next_agreed;

  dph_state_e             state;
  dph_state_e             next_state;
  logic [`DPH_CNT_W-1:0]  cnt;
  logic [`DPH_CNT_W-1:0]  next_cnt;
  dph_req_s               op;
  dph_req_s               next_op;
  logic                   readback;
  logic                   next_readback;
  logic                   was_blocked;
  logic                   next_was_blocked;
  dph_pins_s              next_pins;
  dph_rsp_s               next_rsp;

  wire                    flag_low;
  wire [`DPH_DATA_W-1:0]  dq_agreed;
  wire                    cur_write;
  wire                    cur_token;
  wire                    busy_wait;
  wire [`DPH_CNT_W-1:0]   load_cyc;
  wire [`DPH_CNT_W-1:0]   hold_cyc;
  wire                    n_strobe;
  wire                    n_token;
  wire                    n_write;
  wire                    token_bit;
  wire                    leaving;
  wire                    finishing;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // three-stage capture; the agreed copy only moves when stages two and three match
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sync1  <= `DPH_SYNC_RST;
      sync2  <= `DPH_SYNC_RST;
      sync3  <= `DPH_SYNC_RST;
      agreed <= `DPH_SYNC_RST;
    end else begin
      sync1  <= {CONTENTION_N_IN, MAILBOX_N_IN, DQ_IN};
      sync2  <= sync1;
      sync3  <= sync2;
      agreed <= next_agreed;
    end
  end

  assign next_agreed = (sync2 & sync3) | (agreed & (sync2 ^ sync3));
  assign flag_low    = ~agreed[`DPH_SYNC_W-1];
  assign dq_agreed   = agreed[`DPH_DATA_W-1:0];

  assign cur_write = is_write(op.kind) & ~readback;
  assign cur_token = is_token(op.kind);
  // flag is an input here; it holds memory reads and memory writes, never token accesses
  assign busy_wait = flag_low & ~cur_token;
  assign load_cyc  = cur_write ? LD_WR : (cur_token ? LD_TRD : LD_MRD);
  assign hold_cyc  = cur_write ? LD_WRH : LD_RDH;

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_op          = op;
    next_readback    = readback;
    next_was_blocked = was_blocked;
    unique case (state)
      DPH_ST_IDLE: begin
        if (REQ_VALID) begin
          next_op          = REQ;
          next_readback    = 1'b0;
          next_was_blocked = 1'b0;
          next_state       = DPH_ST_SETUP;
        end
      end
      DPH_ST_SETUP: begin
        next_cnt   = load_cyc;
        next_state = DPH_ST_ACTIVE;
      end
      DPH_ST_ACTIVE: begin
        if (cnt != CNT_ZERO) begin
          next_cnt = cnt - CNT_ONE;
        end else if (busy_wait) begin
          next_cnt         = hold_cyc;
          next_was_blocked = 1'b1;
          next_state       = DPH_ST_BLOCK;
        end else begin
          next_state = DPH_ST_END;
        end
      end
      DPH_ST_BLOCK: begin
        if (busy_wait) begin
          next_cnt = hold_cyc;
        end else if (cnt != CNT_ZERO) begin
          next_cnt = cnt - CNT_ONE;
        end else begin
          next_state = DPH_ST_END;
        end
      end
      DPH_ST_END: begin
        if ((op.kind == DPH_TOK_ACQ) && !readback) begin
          next_cnt      = LD_GAP;
          next_readback = 1'b1;
          next_state    = DPH_ST_GAP;
        end else begin
          next_state = DPH_ST_IDLE;
        end
      end
      DPH_ST_GAP: begin
        if (cnt != CNT_ZERO) begin
          next_cnt = cnt - CNT_ONE;
        end else begin
          next_state = DPH_ST_SETUP;
        end
      end
      default: begin
        next_state = DPH_ST_IDLE;
      end
    endcase
  end

  assign n_strobe  = (next_state == DPH_ST_ACTIVE) || (next_state == DPH_ST_BLOCK);
  assign n_token   = is_token(next_op.kind);
  assign n_write   = is_write(next_op.kind) & ~next_readback;
  // only bit zero carries the token request
  assign token_bit = (next_op.kind == DPH_TOK_ACQ) ? 1'b0 : next_op.wdata[0];

  // address moves only on entry to setup, when the strobe is already high
  // strobe high on address change
  assign next_pins.addr            = next_op.addr;
  assign next_pins.dout            = n_token ? {{(`DPH_DATA_W-1){1'b0}}, token_bit}
                                             : next_op.wdata;
  assign next_pins.dout_en         = n_strobe & n_write;
  assign next_pins.mem_select_n    = ~(n_strobe & ~n_token);
  assign next_pins.token_select_n  = ~(n_strobe & n_token);
  assign next_pins.write_n         = ~(n_strobe & n_write);
  // output enable stays high during writes so the short strobe suffices
  assign next_pins.output_enable_n = ~(n_strobe & ~n_write);

  assign leaving   = (state == DPH_ST_ACTIVE || state == DPH_ST_BLOCK)
                     && (next_state == DPH_ST_END);
  assign finishing = (state == DPH_ST_END) && (next_state == DPH_ST_IDLE);

  assign next_rsp.rdata   = (leaving && !cur_write) ? dq_agreed : RSP.rdata;
  assign next_rsp.granted = (leaving && cur_token && !cur_write) ? ~dq_agreed[0]
                                                                 : RSP.granted;
  assign next_rsp.blocked = leaving ? was_blocked : RSP.blocked;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state       <= DPH_ST_IDLE;
      cnt         <= CNT_ZERO;
      op          <= '{kind: DPH_MEM_RD, addr: `DPH_ADDR_RST, wdata: `DPH_DATA_RST};
      readback    <= 1'b0;
      was_blocked <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      op          <= next_op;
      readback    <= next_readback;
      was_blocked <= next_was_blocked;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      PINS            <= '{addr: `DPH_ADDR_RST, dout: `DPH_DATA_RST, dout_en: 1'b0,
                           mem_select_n: 1'b1, token_select_n: 1'b1,
                           write_n: 1'b1, output_enable_n: 1'b1};
      RSP             <= '{rdata: `DPH_DATA_RST, granted: 1'b0, blocked: 1'b0};
      MAILBOX_PENDING <= 1'b0;
    end else begin
      PINS            <= next_pins;
      RSP             <= next_rsp;
      MAILBOX_PENDING <= ~agreed[`DPH_DATA_W];
    end
  end

  assign REQ_READY = (state == DPH_ST_IDLE);
  assign RSP_VALID = finishing;

endmodule

`default_nettype wire

// [core/dph_port_regs.svh]
/*
  Named constants for the dual-port RAM port controller: pin widths,
  special addresses, device timing figures in ns and the synchroniser depth.
  Assumes it is included by bare name before any package or module uses it.
*/
`ifndef DPH_PORT_REGS_SVH
`define DPH_PORT_REGS_SVH

`define DPH_ADDR_W                  13
`define DPH_DATA_W                  8
`define DPH_CNT_W                   4
`define DPH_SYNC_W                  10

// mailbox words: top address flags the right port, next-lower flags the left
`define DPH_MBOX_TO_RIGHT_ADDR      13'h1fff
`define DPH_MBOX_TO_LEFT_ADDR       13'h1ffe

`define DPH_ADDR_RST                13'h0000
`define DPH_DATA_RST                8'h00
`define DPH_SYNC_RST                10'h3ff

`define DPH_MCLK_NS                 100
`define DPH_WRITE_PULSE_MIN_NS      12
`define DPH_WRITE_TURNOFF_NS        10
`define DPH_DATA_SETUP_NS           10
`define DPH_SELECT_ACCESS_NS        15
`define DPH_OE_ACCESS_NS            10
`define DPH_CROSS_PORT_DELAY_NS     25
`define DPH_RELEASE_STROBE_HOLD_NS  13
`define DPH_RELEASE_DATA_DELAY_NS   15
`define DPH_TOKEN_UPDATE_PULSE_NS   10
`define DPH_TOKEN_WRITE_TO_READ_NS  5

// cycles from a pin change to the agreed copy inside the block
`define DPH_SYNC_LAT                4

`endif

// [core/dph_pkg.sv]
/*
  Types shared by the port controller and its bench: request kinds,
  request and response records, pin bundle and the sequencer states.
  Assumes dph_port_regs.svh is on the include path.
*/
`default_nettype none
`include "dph_port_regs.svh"

package dph_pkg;

  typedef enum logic [1:0] {
    DPH_MEM_RD  = 2'h0,
    DPH_MEM_WR  = 2'h1,
    DPH_TOK_WR  = 2'h2,
    DPH_TOK_ACQ = 2'h3
  } dph_kind_e;

  typedef enum logic [2:0] {
    DPH_ST_IDLE   = 3'h0,
    DPH_ST_SETUP  = 3'h1,
    DPH_ST_ACTIVE = 3'h3,
    DPH_ST_END    = 3'h2,
    DPH_ST_BLOCK  = 3'h7,
    DPH_ST_GAP    = 3'h6
  } dph_state_e;

  typedef struct packed {
    dph_kind_e               kind;
    logic [`DPH_ADDR_W-1:0]  addr;
    logic [`DPH_DATA_W-1:0]  wdata;
  } dph_req_s;

  typedef struct packed {
    logic [`DPH_DATA_W-1:0]  rdata;
    logic                    granted;
    logic                    blocked;
  } dph_rsp_s;

  typedef struct packed {
    logic [`DPH_ADDR_W-1:0]  addr;
    logic [`DPH_DATA_W-1:0]  dout;
    logic                    dout_en;
    logic                    mem_select_n;
    logic                    token_select_n;
    logic                    write_n;
    logic                    output_enable_n;
  } dph_pins_s;

endpackage

`default_nettype wire

// [tb/dph_port_assertions.sv]
/* pin checks and answer covers for the port controller.
   assumes a bind onto dph_port_ctrl from the bench top. */
`default_nettype none
`include "dph_port_regs.svh"
module dph_port_assertions
  import dph_pkg::*;
(
  input wire logic                   MCLK,
  input wire logic                   RESET_N,
  input wire dph_pkg::dph_req_s      REQ,
  input wire logic                   REQ_VALID,
  input wire logic                   REQ_READY,
  input wire dph_pkg::dph_rsp_s      RSP,
  input wire logic                   RSP_VALID,
  input wire dph_pkg::dph_pins_s     PINS,
  input wire logic [`DPH_DATA_W-1:0] DQ_IN,
  input wire logic                   CONTENTION_N_IN,
  input wire logic                   MAILBOX_N_IN,
  input wire logic                   MAILBOX_PENDING
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  addr_quiet_a: assert property (
    !$stable(PINS.addr) |-> PINS.write_n && $past(PINS.write_n)) else $error("addr moved");
  write_window_a: assert property (
    !PINS.write_n |-> PINS.dout_en && !(PINS.mem_select_n && PINS.token_select_n))
    else $error("write outside select");
  oe_off_a: assert property (
    !PINS.write_n |-> PINS.output_enable_n) else $error("oe low in write");
  mem_off_a: assert property (
    !PINS.token_select_n |-> PINS.mem_select_n) else $error("memory selected on token");
  token_gap_a: assert property (
    $rose(PINS.token_select_n) |=> PINS.token_select_n [*2]) else $error("token gap short");
  write_width_a: assert property (
    $fell(PINS.write_n) |-> !PINS.write_n [*5]) else $error("write pulse short");
  strobe_hold_a: assert property (
    $rose(CONTENTION_N_IN) && !PINS.write_n |=> !PINS.write_n [*2])
    else $error("write strobe released early");
  read_hold_a: assert property (
    $rose(CONTENTION_N_IN) && !PINS.output_enable_n |=> !PINS.output_enable_n [*4])
    else $error("blocked read ended early");
  cover property (REQ_VALID && REQ_READY && REQ.kind == DPH_TOK_ACQ);
  cover property (RSP_VALID && RSP.blocked);
  cover property (RSP_VALID && RSP.granted);
endmodule
`default_nettype wire

// [tb/dph_dev_model.sv]
/* behavioural device port: memory, token latch, mailbox and busy flag.
   assumes the bench calls the peer tasks for the far port. */
`default_nettype none
`include "dph_port_regs.svh"
module dph_dev_model
  import dph_pkg::*;
(
  input  wire dph_pkg::dph_pins_s PINS,
  output logic [7:0]              DQ,
  output logic                    BUSY_N,
  output logic                    MBOX_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:8191];
  logic        own = 1'b0, peer = 1'b0, my_req = 1'b0, peer_req = 1'b0, rflag = 1'b0, wt;
  logic [12:0] wa;
  logic [7:0]  wd;
  wire sel   = !(PINS.mem_select_n && PINS.token_select_n);
  wire wr_on = sel && !PINS.write_n;
  wire rd_on = sel && PINS.write_n && !PINS.output_enable_n;
  initial begin
    DQ = 8'h00;
    BUSY_N = 1'b1;
    MBOX_N = 1'b1;
  end
  // latch while both low; decoded from PINS itself so a late wire update cannot race it
  always @(PINS)
    if (!(PINS.mem_select_n && PINS.token_select_n) && !PINS.write_n) begin
      wa = PINS.addr;
      wd = PINS.dout;
      wt = !PINS.token_select_n;
    end
  always @(negedge wr_on)
    if (wt) tok_wr(wd[0]);
    else begin
      mem[wa] = wd;
      if (wa == `DPH_MBOX_TO_RIGHT_ADDR) rflag = 1'b1;
    end
  // floats unless reading; not pulled, so it toggles
  always @(rd_on or PINS.addr or own)
    if (rd_on) DQ <= #15 PINS.token_select_n ? mem[PINS.addr] : {8{!own}};
    else DQ <= #10 ~DQ;
  always @(posedge rd_on)
    if (!PINS.mem_select_n && PINS.addr == `DPH_MBOX_TO_LEFT_ADDR) MBOX_N <= #15 1'b1;
  // bit zero, one owner, pending granted
  task tok_wr(input logic b);
    if (!b && !peer) own = 1'b1;
    else if (!b) my_req = 1'b1;
    else begin
      own = 1'b0;
      my_req = 1'b0;
      peer = peer || peer_req;
      peer_req = 1'b0;
    end
  endtask
  task peer_take;
    if (own) peer_req = 1'b1;
    else peer = 1'b1;
  endtask
  task peer_drop;
    peer = 1'b0;
    peer_req = 1'b0;
    own = own || my_req;
    my_req = 1'b0;
  endtask
  task set_busy(input logic b);
    BUSY_N <= b;
  endtask
  task peer_post;
    MBOX_N <= #15 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
/* self-checking bench for the port controller.
   assumes design, model and checker files are compiled first. */
`default_nettype none
`include "dph_port_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dph_pkg::*;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic       req_valid = 1'b0;
  dph_req_s   req = '0;
  dph_rsp_s   rsp;
  dph_pins_s  pins;
  logic       req_ready, rsp_valid, pending, cont_n, mbox_n;
  logic [7:0] dq;
  int         fail_count = 0;
  int         tests_run = 0;
  int         c;
  dph_port_ctrl i_dut (.MCLK(mclk), .RESET_N(reset_n), .REQ(req), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .RSP(rsp), .RSP_VALID(rsp_valid), .PINS(pins), .DQ_IN(dq),
    .CONTENTION_N_IN(cont_n), .MAILBOX_N_IN(mbox_n), .MAILBOX_PENDING(pending));
  dph_dev_model i_dev (.PINS(pins), .DQ(dq), .BUSY_N(cont_n), .MBOX_N(mbox_n));
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_d(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    cmp_d({7'h00, got}, {7'h00, exp});
  endtask
  // request held for one clock without looking at REQ_READY; c counts cycles to the answer
  task automatic xfer(input dph_kind_e k, input logic [12:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{k, a, d};
    req_valid <= 1'b1;
    @(negedge mclk);
    @(posedge mclk);
    req_valid <= 1'b0;
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (rsp_valid !== 1'b1 && c < 300);
    if (c >= 300) begin
      fail_count++;
      $display("[FAIL] %0t ns no answer", $time);
      wrap_up();
    end
  endtask
  task automatic t_mem;
    xfer(DPH_MEM_WR, 13'h0000, 8'ha5);
    cmp_d(c[7:0], 8'h07);
    xfer(DPH_MEM_WR, 13'h1ffd, 8'h5a);
    cmp_d(i_dev.mem[13'h1ffd], 8'h5a);
    xfer(DPH_MEM_RD, 13'h0000, 8'h00);
    cmp_d(rsp.rdata, 8'ha5);
    xfer(DPH_MEM_RD, 13'h1ffd, 8'h00);
    cmp_d(rsp.rdata, 8'h5a);
    cmp_b(rsp.blocked, 1'b0);
    $display("memory test done");
  endtask
  task automatic t_block;
    for (int i = 0; i < 2; i++) begin
      i_dev.set_busy(1'b0);
      fork
        xfer(i ? DPH_MEM_RD : DPH_MEM_WR, 13'h0010, 8'h3c);
        begin
          repeat (20) @(posedge mclk);
          i_dev.set_busy(1'b1);
        end
      join
      cmp_b(rsp.blocked, 1'b1);
      cmp_b(c > 20, 1'b1);
      cmp_d(i ? rsp.rdata : i_dev.mem[13'h0010], 8'h3c);
      repeat (10) @(posedge mclk);
    end
    $display("contention test done");
  endtask
  task automatic t_token;
    xfer(DPH_TOK_ACQ, 13'h0000, 8'h00);
    cmp_b(rsp.granted, 1'b1);
    xfer(DPH_TOK_WR, 13'h0000, 8'h01);
    cmp_b(i_dev.own, 1'b0);
    i_dev.peer_take();
    xfer(DPH_TOK_ACQ, 13'h0000, 8'h00);
    cmp_b(rsp.granted, 1'b0);
    i_dev.peer_drop();
    cmp_b(i_dev.own, 1'b1);
    xfer(DPH_TOK_ACQ, 13'h0000, 8'h00);
    cmp_b(rsp.granted, 1'b1);
    $display("token test done");
  endtask
  task automatic t_mbox;
    xfer(DPH_MEM_WR, `DPH_MBOX_TO_RIGHT_ADDR, 8'h77);
    cmp_b(i_dev.rflag, 1'b1);
    i_dev.peer_post();
    repeat (8) @(negedge mclk);
    cmp_b(pending, 1'b1);
    xfer(DPH_MEM_RD, `DPH_MBOX_TO_LEFT_ADDR, 8'h00);
    repeat (8) @(negedge mclk);
    cmp_b(pending, 1'b0);
    $display("mailbox test done");
  endtask
  initial forever #50 mclk = ~mclk;
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(negedge mclk);
    cmp_b(pins.write_n, 1'b1);
    cmp_b(req_ready, 1'b1);
    t_mem;
    t_block;
    t_token;
    t_mbox;
    wrap_up;
  end
endmodule
bind dph_port_ctrl dph_port_assertions i_chk (.MCLK(MCLK), .RESET_N(RESET_N), .REQ(REQ),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP(RSP), .RSP_VALID(RSP_VALID),
  .PINS(PINS), .DQ_IN(DQ_IN), .CONTENTION_N_IN(CONTENTION_N_IN),
  .MAILBOX_N_IN(MAILBOX_N_IN), .MAILBOX_PENDING(MAILBOX_PENDING));
`default_nettype wire
